// >>> hdl/dacuc_pkg.sv
// Constants shared by the DAC update and clear control logic.
// Assumes a 32-bit command frame with the command nibble in bits 27..24.
package dacuc_pkg;

   localparam int NUM_CH     = 16;
   localparam int CODE_W     = 12;
   localparam int ADDR_W     = 4;
   localparam int MASK_W     = 8;
   localparam int FRAME_BITS = 32;
   localparam int CNT_W      = 6;

   // Frame field positions
   localparam int CMD_HI     = 27;
   localparam int CMD_LO     = 24;
   localparam int ADDR_HI    = 23;
   localparam int ADDR_LO    = 20;
   localparam int DATA_HI    = 19;
   localparam int DATA_LO    = 8;
   localparam int SEL_HI     = 1;
   localparam int SEL_LO     = 0;
   localparam int MASK_HI    = 7;
   localparam int MASK_LO    = 0;

   localparam logic [CNT_W-1:0] LAST_BIT = 6'h1f;

   // Command nibble values
   localparam logic [3:0] CMD_WRITE_IN    = 4'h0;
   localparam logic [3:0] CMD_UPDATE_N    = 4'h1;
   localparam logic [3:0] CMD_WRITE_UPD_N = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPD_A = 4'h3;
   localparam logic [3:0] CMD_CLEAR_SEL   = 4'h5;
   localparam logic [3:0] CMD_OVERRIDE    = 4'h6;

   // Clear code selection and the codes it picks
   localparam logic [1:0] SEL_ZERO = 2'h0;
   localparam logic [1:0] SEL_MID  = 2'h1;
   localparam logic [1:0] SEL_FULL = 2'h2;
   localparam logic [1:0] SEL_NOP  = 2'h3;

   localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
   localparam logic [CODE_W-1:0] CODE_MID  = 12'h800;
   localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;

   localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;

endpackage : dacuc_pkg

// >>> hdl/dacuc_sync.sv
// Two-flop level synchroniser for a group of independent bits.
// Assumes each bit is a level or a toggle from another clock or a pin.
`timescale 1ns/1ps
module dacuc_sync #(
   parameter int          WIDTH = 1,
   parameter logic [31:0] INIT  = 32'h0000_0000
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds only the second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= INIT[WIDTH-1:0];
         sync_out <= INIT[WIDTH-1:0];
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : dacuc_sync

// >>> hdl/dacuc_ctrl.sv
// DAC update and clear control: serial frame receiver on the DAC serial
// clock, input and DAC registers for sixteen channels, clear code and
// per-channel load override.
// Assumes frame_sync_n frames each 32-bit write; the serial clock may stop
// between frames; strobe pins are asynchronous to clk.
//
// Summary of operation
// - Clear selection 00, 01, 10 give codes 0x000, 0x800, 0xfff; 11 keeps code.
// - Clear frame: command in bits 27..24, selection in bits 1..0, rest ignored.
// - Synchronous load: with the load strobe low, new data reaches the DAC register once the word handed over at the 32nd clock crosses into clk.
// - Asynchronous load: writes wait; load strobe falling copies inputs to DACs.
// - Command 0011 writes the addressed input then updates all DAC registers.
// - Override bit 1 updates its channel on every write, ignoring the strobe.
// - Command 0110 loads the eight-bit override mask; mask resets to zero.
// - Override frame: bit 0 is channel A, bit 7 channel H; rest ignored.
// - Clear strobe falling edge loads all input and DAC registers with clear code.
// - Clear strobe during a frame discards that frame.
// - After power-on the stored clear code is zero scale.
// - Command 0101 loads the clear code selection from the frame.
`timescale 1ns/1ps
module dacuc_ctrl
   import dacuc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     dac_serial_clock,
   input  wire logic                     frame_sync_n,
   input  wire logic                     dac_serial_data,
   input  wire logic                     load_strobe_n,
   input  wire logic                     clear_strobe_n,
   output      logic [NUM_CH*CODE_W-1:0] dac_code,
   output      logic [NUM_CH*CODE_W-1:0] input_code,
   output      logic [CODE_W-1:0]        clear_code,
   output      logic [MASK_W-1:0]        override_mask,
   output      logic                     frame_exec,
   output      logic                     frame_discard
);

   // Link domain: shift register and bit counter

   logic [FRAME_BITS-1:0] shift_reg;
   logic [CNT_W-1:0]      bit_cnt_reg;
   logic [FRAME_BITS-1:0] frame_word_reg;
   logic                  done_tgl_reg;
   logic                  link_rst_n;

   // Sync high between frames restarts the count, so a partial frame is lost
   assign link_rst_n = reset_n & ~frame_sync_n;

   always_ff @(negedge dac_serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt_reg <= '0;
      end else if (bit_cnt_reg != LAST_BIT + 6'h01) begin
         bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
   end

   always_ff @(negedge dac_serial_clock or negedge reset_n) begin
      if (!reset_n) begin
         shift_reg <= '0;
      end else if (!frame_sync_n) begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], dac_serial_data};
      end
   end

   // The 32nd falling edge hands the full word over with a toggle
   always_ff @(negedge dac_serial_clock or negedge reset_n) begin
      if (!reset_n) begin
         frame_word_reg <= '0;
         done_tgl_reg   <= 1'b0;
      end else if (!frame_sync_n && bit_cnt_reg == LAST_BIT) begin
         frame_word_reg <= {shift_reg[FRAME_BITS-2:0], dac_serial_data};
         done_tgl_reg   <= ~done_tgl_reg;
      end
   end

   // Crossings into clk

   logic done_tgl_s;
   logic busy_s;
   logic load_n_s;
   logic clear_n_s;

   dacuc_sync #(
      .WIDTH (4),
      .INIT  (32'h0000_0003)
   ) u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in ({done_tgl_reg, ~frame_sync_n, load_strobe_n, clear_strobe_n}),
      .sync_out ({done_tgl_s, busy_s, load_n_s, clear_n_s})
   );

   logic done_prev_reg;
   logic busy_prev_reg;
   logic load_prev_reg;
   logic clear_prev_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_prev_reg  <= 1'b0;
         busy_prev_reg  <= 1'b0;
         load_prev_reg  <= 1'b1;
         clear_prev_reg <= 1'b1;
      end else begin
         done_prev_reg  <= done_tgl_s;
         busy_prev_reg  <= busy_s;
         load_prev_reg  <= load_n_s;
         clear_prev_reg <= clear_n_s;
      end
   end

   logic frame_arrive;
   logic frame_start;
   logic load_fall;
   logic clear_fall;

   assign frame_arrive = done_tgl_s ^ done_prev_reg;
   assign frame_start  = busy_s & ~busy_prev_reg;
   assign load_fall    = load_prev_reg & ~load_n_s;
   assign clear_fall   = clear_prev_reg & ~clear_n_s;

   // Abort tracking: a clear seen while the frame is open spoils it.
   // The flag outlives the frame so the late word hand-over still sees it.
   logic abort_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         abort_reg <= 1'b0;
      end else if (clear_fall && (busy_s || frame_arrive)) begin
         abort_reg <= 1'b1;
      end else if (frame_arrive || frame_start) begin
         abort_reg <= 1'b0;
      end
   end

   logic frame_ok;

   assign frame_ok = frame_arrive & ~abort_reg & ~clear_fall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_exec    <= 1'b0;
         frame_discard <= 1'b0;
      end else begin
         frame_exec    <= frame_ok;
         frame_discard <= frame_arrive & ~frame_ok;
      end
   end

   // Frame fields; the word is stable for a whole frame after hand-over

   logic [3:0]        cmd;
   logic [ADDR_W-1:0] addr;
   logic [CODE_W-1:0] wdata;

   assign cmd   = frame_word_reg[CMD_HI:CMD_LO];
   assign addr  = frame_word_reg[ADDR_HI:ADDR_LO];
   assign wdata = frame_word_reg[DATA_HI:DATA_LO];

   function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] want);
      is_cmd = (c == want);
   endfunction : is_cmd

   logic cmd_write;
   logic cmd_upd_n;
   logic cmd_upd_all;

   assign cmd_write   = frame_ok & (is_cmd(cmd, CMD_WRITE_IN) | is_cmd(cmd, CMD_WRITE_UPD_N)
                                    | is_cmd(cmd, CMD_WRITE_UPD_A));
   assign cmd_upd_n   = frame_ok & (is_cmd(cmd, CMD_UPDATE_N) | is_cmd(cmd, CMD_WRITE_UPD_N));
   assign cmd_upd_all = frame_ok & is_cmd(cmd, CMD_WRITE_UPD_A);

   // Clear code store

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clear_code <= CODE_ZERO;
      end else if (frame_ok && is_cmd(cmd, CMD_CLEAR_SEL)) begin
         unique case (frame_word_reg[SEL_HI:SEL_LO])
            SEL_ZERO: clear_code <= CODE_ZERO;
            SEL_MID:  clear_code <= CODE_MID;
            SEL_FULL: clear_code <= CODE_FULL;
            SEL_NOP:  clear_code <= clear_code;
         endcase
      end
   end

   // Override mask

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         override_mask <= MASK_RESET;
      end else if (frame_ok && is_cmd(cmd, CMD_OVERRIDE)) begin
         override_mask <= frame_word_reg[MASK_HI:MASK_LO];
      end
   end

   // Channel registers. Each mask bit serves one channel in each bank of
   // eight, so channels n and n+8 share an override bit.

   logic [CODE_W-1:0] in_reg  [NUM_CH];
   logic [CODE_W-1:0] dac_reg [NUM_CH];

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         logic hit;
         logic ovr;

         assign hit = (addr == ADDR_W'(ch));
         assign ovr = override_mask[ch % MASK_W];

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               in_reg[ch] <= CODE_ZERO;
            end else if (clear_fall) begin
               in_reg[ch] <= clear_code;
            end else if (cmd_write && hit) begin
               in_reg[ch] <= wdata;
            end
         end

         // Clear beats everything; a software update-all beats the pin
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               dac_reg[ch] <= CODE_ZERO;
            end else if (clear_fall) begin
               dac_reg[ch] <= clear_code;
            end else if (cmd_upd_all) begin
               dac_reg[ch] <= hit ? wdata : in_reg[ch];
            end else if (cmd_upd_n && hit) begin
               dac_reg[ch] <= cmd_write ? wdata : in_reg[ch];
            end else if (cmd_write && hit && (!load_n_s || ovr)) begin
               dac_reg[ch] <= wdata;
            end else if (load_fall && !ovr) begin
               dac_reg[ch] <= in_reg[ch];
            end
         end

         assign dac_code[ch*CODE_W +: CODE_W]   = dac_reg[ch];
         assign input_code[ch*CODE_W +: CODE_W] = in_reg[ch];
      end
   endgenerate

endmodule : dacuc_ctrl

// >>> test/dacuc_host.sv
// Host model: drives 32-bit command frames on the DAC serial port.
// Assumes the bench calls send; the link clock idles high between frames.
`timescale 1ns/1ps
module dacuc_host (
   output logic dac_serial_clock,
   output logic frame_sync_n,
   output logic dac_serial_data
);
   initial begin
      dac_serial_clock = 1'b1;
      frame_sync_n     = 1'b1;
      dac_serial_data  = 1'b0;
   end
   task automatic send(input logic [31:0] w);
      frame_sync_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         dac_serial_data = w[i];
         #16 dac_serial_clock = 1'b0;
         #16 dac_serial_clock = 1'b1;
      end
      frame_sync_n = 1'b1;
      // A released line must not keep showing the last bit
      dac_serial_data = ~w[0];
   endtask : send
endmodule : dacuc_host

// >>> test/dacuc_ctrl_props.sv
// Checker for the DAC update and clear control ports.
// Assumes strobe pins are held at least four clk cycles per level.
`timescale 1ns/1ps
module dacuc_ctrl_props
   import dacuc_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     reset_n,
   input wire logic                     dac_serial_clock,
   input wire logic                     frame_sync_n,
   input wire logic                     dac_serial_data,
   input wire logic                     load_strobe_n,
   input wire logic                     clear_strobe_n,
   input wire logic [NUM_CH*CODE_W-1:0] dac_code,
   input wire logic [NUM_CH*CODE_W-1:0] input_code,
   input wire logic [CODE_W-1:0]        clear_code,
   input wire logic [MASK_W-1:0]        override_mask,
   input wire logic                     frame_exec,
   input wire logic                     frame_discard
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_clear_fell;
      $fell(clear_strobe_n);
   endsequence
   sequence s_all_cleared;
      input_code == {NUM_CH{clear_code}} && dac_code == {NUM_CH{clear_code}};
   endsequence
   a_clear_loads_all: assert property (s_clear_fell |-> ##[2:4] s_all_cleared)
      else $error("clear strobe did not load the clear code");
   a_exec_one_cycle: assert property (frame_exec |=> !frame_exec)
      else $error("frame_exec longer than one cycle");
   a_discard_one_cycle: assert property (frame_discard |=> !frame_discard)
      else $error("frame_discard longer than one cycle");
   a_exec_not_discard: assert property (!(frame_exec && frame_discard))
      else $error("frame both executed and discarded");
   a_clear_code_legal: assert property (clear_code inside {12'h000, 12'h800, 12'hfff})
      else $error("clear code outside the selectable set");
   a_mask_on_exec: assert property ($changed(override_mask) |-> frame_exec)
      else $error("override mask changed without a frame");
   a_code_on_exec: assert property ($changed(clear_code) |-> frame_exec)
      else $error("clear code changed without a frame");
   a_input_cause: assert property ($changed(input_code) |->
      frame_exec || input_code == {NUM_CH{clear_code}})
      else $error("input register changed without a frame or clear");
   a_dac_cause: assert property ($changed(dac_code) |->
      frame_exec || !load_strobe_n || dac_code == {NUM_CH{clear_code}})
      else $error("DAC register changed without a cause");
endmodule : dacuc_ctrl_props
bind dacuc_ctrl dacuc_ctrl_props u_props (.clk, .reset_n, .dac_serial_clock, .frame_sync_n, .dac_serial_data,
   .load_strobe_n, .clear_strobe_n, .dac_code, .input_code, .clear_code, .override_mask, .frame_exec, .frame_discard);

// >>> test/dacuc_ctrl_bench.sv
// Self-checking bench for the DAC update and clear control block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module dacuc_ctrl_bench;
   logic clk, reset_n, load_strobe_n, clear_strobe_n, frame_exec, frame_discard;
   logic dac_serial_clock, frame_sync_n, dac_serial_data;
   logic [191:0] dac_code, input_code, in_m, dac_m;
   logic [11:0]  clear_code, cc;
   logic [7:0]   override_mask, mask;
   logic [31:0]  w;
   int           seed, error_cnt, cmp_count;
   dacuc_ctrl DUT (.clk, .reset_n, .dac_serial_clock, .frame_sync_n, .dac_serial_data, .load_strobe_n,
      .clear_strobe_n, .dac_code, .input_code, .clear_code, .override_mask, .frame_exec, .frame_discard);
   dacuc_host host (.dac_serial_clock, .frame_sync_n, .dac_serial_data);
   always #2.5 clk = ~clk;
   task automatic print_verdict();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic chk(input string n);
      cmp_count++;
      if ({input_code, dac_code, clear_code, override_mask} !== {in_m, dac_m, cc, mask}) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, {in_m, dac_m, cc, mask},
            {input_code, dac_code, clear_code, override_mask});
      end
   endtask : chk
   task automatic wait_for(ref logic f);
      int n = 0;
      while (f !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1 n++;
      end
      if (f !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] handshake expected 1 seen %b", f);
         print_verdict();
      end
   endtask : wait_for
   task automatic pin(ref logic p, input logic v);
      @(posedge clk);
      #1 p = v;
      repeat (4) @(posedge clk);
      #1;
   endtask : pin
   function automatic logic [11:0] clr_of(input logic [1:0] s, input logic [11:0] old);
      case (s)
         2'h0: return 12'h000;
         2'h1: return 12'h800;
         2'h2: return 12'hfff;
         default: return old;
      endcase
   endfunction : clr_of
   task automatic frame(input logic [31:0] f);
      int a;
      a = f[23:20];
      fork
         host.send(f);
         wait_for(frame_exec);
      join
      if (f[27:24] inside {4'h0, 4'h2, 4'h3})
         in_m[a*12 +: 12] = f[19:8];
      case (f[27:24])
         4'h0: if (!load_strobe_n || mask[a%8]) dac_m[a*12 +: 12] = f[19:8];
         4'h1, 4'h2: dac_m[a*12 +: 12] = in_m[a*12 +: 12];
         4'h3: dac_m = in_m;
         4'h5: cc = clr_of(f[1:0], cc);
         4'h6: mask = f[7:0];
         default: ;
      endcase
      chk("frame");
      repeat (4) @(posedge clk);
   endtask : frame
   initial begin
      // Clock low, reset asserted, both strobes idle high, models zeroed
      {clk, reset_n, load_strobe_n, clear_strobe_n, in_m, dac_m, cc, mask} = {4'h3, 404'h0};
      {seed, error_cnt, cmp_count} = {32'd91, 64'd0};
      repeat (5) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("reset");
      for (int s = 0; s < 4; s++) begin
         w = $random(seed);
         w[27:24] = 4'h5;
         w[1:0] = s[1:0];
         frame(w);
         pin(clear_strobe_n, 1'b0);
         in_m = {16{cc}};
         dac_m = in_m;
         chk("clear");
         pin(clear_strobe_n, 1'b1);
      end
      w = $random(seed);
      w[27:24] = 4'h6;
      frame(w);
      for (int i = 0; i < 24; i++) begin
         if (i == 12) begin
            pin(load_strobe_n, 1'b0);
            for (int c = 0; c < 16; c++)
               if (!mask[c%8]) dac_m[c*12 +: 12] = in_m[c*12 +: 12];
            chk("load strobe");
         end
         w = $random(seed);
         w[27:26] = 2'h0;
         frame(w);
      end
      pin(load_strobe_n, 1'b1);
      w = $random(seed);
      w[27:24] = 4'h0;
      fork
         host.send(w);
         begin
            #300 clear_strobe_n = 1'b0;
            wait_for(frame_discard);
         end
      join
      in_m = {16{cc}};
      dac_m = in_m;
      repeat (4) @(posedge clk);
      #1 chk("abort");
      pin(clear_strobe_n, 1'b1);
      print_verdict();
   end
endmodule : dacuc_ctrl_bench
